// ==== rtl/acr_pkg.sv ====
// constants and types of the converter configuration register block
//
// Contract
// - command 1100b returns configuration on serial output
// - read-back needs no start strobe, status pin quiet
// - read-back sends result nibble, then twelve bits
// - bit 11 selects manual or automatic sequencing
// - bit 10 selects serial clock half or oscillator
// - bit 9 selects auto trigger or start pin
// - auto trigger forces the auto-nap bit ignored
// - bit 7 sets status pin polarity
// - bit 6 selects interrupt or conversion-done function
// - bit 5 clear turns status pin into chain input
// - bit 4 clear enables auto-nap
// - bit 3 clear naps, wake command sets it
// - bit 2 clear deep powerdown, wake sets it
// - bit 1 tags 17th clock, single variant zero
// - reset leaves every bit one, tag zero on single variant only
// - command 1110b plus twelve bits, takes 16th edge
// - input sampled and output changed on falling edge
package acr_pkg;
  // ********************************************************************
  // command nibble codes
  // ********************************************************************
  localparam logic [3:0] CMD_WAKE = 4'hb;
  localparam logic [3:0] CMD_READ_CFG = 4'hc;
  localparam logic [3:0] CMD_WRITE_CFG = 4'he;
  localparam logic [3:0] CMD_DEFAULT = 4'hf;
  // ********************************************************************
  // frame bit counts (zero based falling edge counts)
  // ********************************************************************
  localparam logic [4:0] EDGE_CMD_DONE = 5'h03;
  localparam logic [4:0] EDGE_WORD_DONE = 5'h0f;
  localparam logic [4:0] EDGE_MAX = 5'h1f;
  // ********************************************************************
  // configuration field positions
  // ********************************************************************
  localparam int BIT_AUTO_SEQ = 11;
  localparam int BIT_OSC_CLK = 10;
  localparam int BIT_MANUAL_TRIG = 9;
  localparam int BIT_STATUS_LOW = 7;
  localparam int BIT_STATUS_EOC = 6;
  localparam int BIT_STATUS_OUT = 5;
  localparam int BIT_NAP_OFF = 4;
  localparam int BIT_NAP_RUN = 3;
  localparam int BIT_DEEP_RUN = 2;
  localparam int BIT_TAG = 1;
  localparam int BIT_RUN = 0;
  // ********************************************************************
  // reset values and masks
  // ********************************************************************
  localparam logic [11:0] CFG_ALL = 12'hfff;
  localparam logic [11:0] CFG_NO_TAG = 12'hffd;
  localparam logic [15:0] OUT_ONES = 16'hffff;
  // ********************************************************************
  // timing: internal clocks from done inactive to auto start
  // ********************************************************************
  localparam logic [2:0] AUTO_TRIG_CLOCKS = 3'h4;
  typedef enum logic [0:0] {
    ACR_IDLE = 1'b0,
    ACR_ACTIVE = 1'b1
  } acr_frame_type;
endpackage

// ==== rtl/acr_config_register.sv ====
// serial configuration register of the sampling converter
`timescale 1ns/1ns
module acr_config_register #(
  parameter logic DUAL_CHANNEL = 1'b1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic frame_select_n,
  input wire logic sdi,
  input wire logic conversion_start_n,
  input wire logic chain_serial_in,
  input wire logic [15:0] conv_result,
  input wire logic channel_tag,
  input wire logic eoc_level,
  input wire logic int_level,
  input wire logic osc_tick,
  output logic sdo,
  output logic sdo_oe,
  output logic status_out,
  output logic status_oe,
  output logic chain_bit,
  output logic [11:0] config_word,
  output logic auto_channel_seq,
  output logic manual_trigger,
  output logic auto_nap_en,
  output logic nap_powerdown,
  output logic deep_powerdown,
  output logic tag_enable,
  output logic chain_mode,
  output logic soft_reset,
  output logic conv_clock,
  output logic conv_start
);
  // single channel parts keep the tag bit at zero
  localparam logic [11:0] CFG_KEEP = DUAL_CHANNEL ? acr_pkg::CFG_ALL : acr_pkg::CFG_NO_TAG;
  // ********************************************************************
  // serial frame state
  // ********************************************************************
  acr_pkg::acr_frame_type state, next_state;
  logic sclk_q, fs_q, next_sdo, next_sdo_oe, cfg_read, next_cfg_read;
  logic ones_flag, next_ones_flag, next_soft_reset, sclk_fall, frame_start, in_frame_fall;
  logic [4:0] bit_count, next_bit_count;
  logic [15:0] shift_in, next_shift_in, out_shift, next_out_shift;
  logic [11:0] next_config;
  logic [3:0] cmd_now;
  logic [15:0] word_now;
  assign sclk_fall = sclk_q & ~sclk;
  assign frame_start = fs_q & ~frame_select_n;
  assign in_frame_fall = (state == acr_pkg::ACR_ACTIVE) & ~frame_select_n & sclk_fall;
  assign cmd_now = {shift_in[2:0], sdi};
  assign word_now = {shift_in[14:0], sdi};
  // frame sequencing, shifting and command decode
  always_comb begin
    next_state = state;
    next_bit_count = bit_count;
    next_shift_in = shift_in;
    next_out_shift = out_shift;
    next_sdo = sdo;
    next_sdo_oe = sdo_oe;
    next_cfg_read = cfg_read;
    next_ones_flag = ones_flag;
    next_config = config_word;
    next_soft_reset = 1'b0;
    if (frame_start) begin
      // result msb, or all ones after a reset, first at frame fall
      next_state = acr_pkg::ACR_ACTIVE;
      next_bit_count = 5'h00;
      next_out_shift = ones_flag ? acr_pkg::OUT_ONES : conv_result;
      next_sdo = next_out_shift[15];
      next_sdo_oe = 1'b1;
      next_cfg_read = 1'b0;
    end else if (state == acr_pkg::ACR_ACTIVE && frame_select_n) begin
      // frame end releases the output; a reset raised late in a frame must survive it
      next_state = acr_pkg::ACR_IDLE;
      next_sdo = 1'b0;
      next_sdo_oe = 1'b0;
      next_cfg_read = 1'b0;
    end else if (in_frame_fall) begin
      // sample and shift on falling edge
      next_shift_in = word_now;
      next_out_shift = {out_shift[14:0], 1'b0};
      next_sdo = out_shift[14];
      if (bit_count != acr_pkg::EDGE_MAX) begin
        next_bit_count = bit_count + 5'h01;
      end
      if (bit_count == acr_pkg::EDGE_CMD_DONE) begin
        next_ones_flag = 1'b0; // all-ones frame spent once its command is known
        // read command swaps in the configuration
        if (cmd_now == acr_pkg::CMD_READ_CFG && !ones_flag) begin
          next_out_shift = {config_word, 4'h0};
          next_sdo = config_word[11];
          // status pin frozen while reading back
          next_cfg_read = 1'b1;
        end
        if (cmd_now == acr_pkg::CMD_WAKE) begin
          next_config[acr_pkg::BIT_NAP_RUN] = 1'b1;
          next_config[acr_pkg::BIT_DEEP_RUN] = 1'b1;
        end
        if (cmd_now == acr_pkg::CMD_DEFAULT) begin
          next_config = acr_pkg::CFG_ALL & CFG_KEEP;
        end
      end
      if (bit_count == acr_pkg::EDGE_WORD_DONE) begin
        // tag on the 17th clock when enabled
        next_sdo = tag_enable & ~cfg_read & channel_tag;
        // write takes effect at the 16th edge
        if (word_now[15:12] == acr_pkg::CMD_WRITE_CFG) begin
          next_config = word_now[11:0] & CFG_KEEP;
          if (!word_now[acr_pkg::BIT_RUN]) begin
            next_config = acr_pkg::CFG_ALL & CFG_KEEP;
            next_soft_reset = 1'b1;
            next_ones_flag = 1'b1;
          end
        end
      end
    end
  end
  // serial group registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= acr_pkg::ACR_IDLE;
      sclk_q <= 1'b0;
      fs_q <= 1'b1;
      bit_count <= 5'h00;
      shift_in <= 16'h0000;
      out_shift <= 16'h0000;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      cfg_read <= 1'b0;
      ones_flag <= 1'b1;
      config_word <= acr_pkg::CFG_ALL & CFG_KEEP;
      soft_reset <= 1'b0;
    end else begin
      state <= next_state;
      sclk_q <= sclk;
      fs_q <= frame_select_n;
      bit_count <= next_bit_count;
      shift_in <= next_shift_in;
      out_shift <= next_out_shift;
      sdo <= next_sdo;
      sdo_oe <= next_sdo_oe;
      cfg_read <= next_cfg_read;
      ones_flag <= next_ones_flag;
      config_word <= next_config;
      soft_reset <= next_soft_reset;
    end
  end
  // ********************************************************************
  // conversion control, status pin and decoded fields
  // ********************************************************************
  logic conv_div, next_conv_div, next_conv_clock, next_conv_start, eoc_q, start_q;
  logic trig_armed, next_trig_armed, next_status_out, next_chain_bit;
  logic [2:0] trig_count, next_trig_count;
  logic [7:0] next_decode;
  // one cycle of decode latency keeps every output on a flip-flop
  always_comb begin
    next_trig_armed = trig_armed;
    next_trig_count = trig_count;
    next_conv_start = 1'b0;
    // half serial clock or oscillator tick
    next_conv_div = conv_div ^ sclk_fall;
    next_conv_clock = config_word[acr_pkg::BIT_OSC_CLK] ? osc_tick : (sclk_fall & conv_div);
    // manual start on falling start pin
    if (config_word[acr_pkg::BIT_MANUAL_TRIG]) begin
      next_conv_start = start_q & ~conversion_start_n;
      next_trig_armed = 1'b0;
    end else if (eoc_q && !eoc_level) begin
      // auto start after four internal clocks
      next_trig_armed = 1'b1;
      next_trig_count = acr_pkg::AUTO_TRIG_CLOCKS;
    end else if (trig_armed && conv_clock) begin
      next_trig_count = trig_count - 3'h1;
      if (trig_count == 3'h1) begin
        next_trig_armed = 1'b0;
        next_conv_start = 1'b1;
      end
    end
    next_status_out = (config_word[acr_pkg::BIT_STATUS_EOC] ? eoc_level : int_level)
                      ^ config_word[acr_pkg::BIT_STATUS_LOW];
    if (cfg_read) begin
      next_status_out = status_out;
    end
    // chain input when direction bit clear
    next_chain_bit = ~config_word[acr_pkg::BIT_STATUS_OUT] & chain_serial_in;
    next_decode[0] = config_word[acr_pkg::BIT_AUTO_SEQ];
    next_decode[1] = config_word[acr_pkg::BIT_MANUAL_TRIG];
    // auto trigger ignores auto-nap; auto-nap when clear
    next_decode[2] = config_word[acr_pkg::BIT_MANUAL_TRIG] & ~config_word[acr_pkg::BIT_NAP_OFF];
    next_decode[3] = ~config_word[acr_pkg::BIT_NAP_RUN];
    next_decode[4] = ~config_word[acr_pkg::BIT_DEEP_RUN];
    // tag enable, zero on single variant
    next_decode[5] = config_word[acr_pkg::BIT_TAG] & DUAL_CHANNEL;
    next_decode[6] = ~config_word[acr_pkg::BIT_STATUS_OUT];
    next_decode[7] = config_word[acr_pkg::BIT_STATUS_OUT];
  end
  // conversion group registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      conv_div <= 1'b0;
      conv_clock <= 1'b0;
      conv_start <= 1'b0;
      eoc_q <= 1'b0;
      start_q <= 1'b1;
      trig_armed <= 1'b0;
      trig_count <= 3'h0;
      status_out <= 1'b1;
      status_oe <= 1'b1;
      chain_bit <= 1'b0;
      auto_channel_seq <= 1'b1;
      manual_trigger <= 1'b1;
      auto_nap_en <= 1'b0;
      nap_powerdown <= 1'b0;
      deep_powerdown <= 1'b0;
      tag_enable <= 1'b0;
      chain_mode <= 1'b0;
    end else begin
      conv_div <= next_conv_div;
      conv_clock <= next_conv_clock;
      conv_start <= next_conv_start;
      eoc_q <= eoc_level;
      start_q <= conversion_start_n;
      trig_armed <= next_trig_armed;
      trig_count <= next_trig_count;
      status_out <= next_status_out;
      status_oe <= next_decode[7];
      chain_bit <= next_chain_bit;
      auto_channel_seq <= next_decode[0];
      manual_trigger <= next_decode[1];
      auto_nap_en <= next_decode[2];
      nap_powerdown <= next_decode[3];
      deep_powerdown <= next_decode[4];
      tag_enable <= next_decode[5];
      chain_mode <= next_decode[6];
    end
  end
  // ********************************************************************
  // assertions
  // ********************************************************************
  // result msb leads the frame
  a_first_bit_result: assert property (@(posedge clk) disable iff (sys_rst)
    frame_start && !ones_flag |=> sdo_oe && sdo == $past(conv_result[15]))
    else $error("frame did not open with result msb");
  a_read_cfg_load: assert property (@(posedge clk) disable iff (sys_rst)
    in_frame_fall && bit_count == acr_pkg::EDGE_CMD_DONE && cmd_now == acr_pkg::CMD_READ_CFG
    && !ones_flag |=> cfg_read && sdo == $past(config_word[11]))
    else $error("read-back did not present configuration");
  a_status_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_read |=> $stable(status_out))
    else $error("status pin moved during read-back");
  // write lands at the 16th edge
  a_write_cfg: assert property (@(posedge clk) disable iff (sys_rst)
    in_frame_fall && bit_count == acr_pkg::EDGE_WORD_DONE
    && word_now[15:12] == acr_pkg::CMD_WRITE_CFG && word_now[0]
    |=> config_word == ($past(word_now[11:0]) & CFG_KEEP))
    else $error("configuration write not applied");
  a_wake_sets: assert property (@(posedge clk) disable iff (sys_rst)
    in_frame_fall && bit_count == acr_pkg::EDGE_CMD_DONE && cmd_now == acr_pkg::CMD_WAKE |=>
    config_word[3] && config_word[2] ##1 !nap_powerdown && !deep_powerdown)
    else $error("wake did not leave powerdown");
  // software reset restores defaults and all-ones output
  a_soft_reset: assert property (@(posedge clk) disable iff (sys_rst)
    soft_reset |-> config_word == (acr_pkg::CFG_ALL & CFG_KEEP) && ones_flag)
    else $error("software reset did not restore defaults");
  a_auto_nap_off: assert property (@(posedge clk) disable iff (sys_rst)
    !config_word[acr_pkg::BIT_MANUAL_TRIG] |=> !auto_nap_en)
    else $error("auto-nap active under auto trigger");
  // manual start follows the pin edge
  a_manual_trig: assert property (@(posedge clk) disable iff (sys_rst)
    config_word[acr_pkg::BIT_MANUAL_TRIG] && start_q && !conversion_start_n |=> conv_start)
    else $error("manual start edge missed");
  a_clk_select: assert property (@(posedge clk) disable iff (sys_rst)
    config_word[acr_pkg::BIT_OSC_CLK] |=> conv_clock == $past(osc_tick))
    else $error("conversion clock source wrong");
  // input sampled on the falling edge
  a_sample_fall: assert property (@(posedge clk) disable iff (sys_rst)
    in_frame_fall |=> shift_in[0] == $past(sdi))
    else $error("serial input not sampled on falling edge");
  c_read_back: cover property (@(posedge clk) disable iff (sys_rst) cfg_read);
  c_write: cover property (@(posedge clk) disable iff (sys_rst)
    in_frame_fall && bit_count == acr_pkg::EDGE_WORD_DONE
    && word_now[15:12] == acr_pkg::CMD_WRITE_CFG);
  c_soft_reset: cover property (@(posedge clk) disable iff (sys_rst) soft_reset);
  c_auto_start: cover property (@(posedge clk) disable iff (sys_rst)
    conv_start && !config_word[acr_pkg::BIT_MANUAL_TRIG]);
endmodule // acr_config_register

// ==== verif/acr_spi_host.sv ====
// serial host model that frames, clocks and exchanges words with the register
`timescale 1ns/1ns
module acr_spi_host (
  input wire logic clk,
  output logic sclk,
  output logic frame_select_n,
  output logic sdi,
  input wire logic sdo,
  input wire logic status_out,
  output logic status_moved
);
  // idle: serial clock stands still low, frame deselected
  initial begin
    sclk = 1'b0;
    frame_select_n = 1'b1;
    sdi = 1'b0;
    status_moved = 1'b0;
  end
  // ********************************************************************
  // one framed transfer of n bits, msb first
  // ********************************************************************
  // command nibble first
  task automatic xfer(input int n, input logic [31:0] wd, output logic [31:0] rd);
    logic held;
    held = 1'b0;
    rd = '0;
    status_moved = 1'b0;
    @(posedge clk) frame_select_n <= 1'b0;
    repeat (3) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b1;
      sdi <= wd[n-1-i];
      repeat (3) @(posedge clk);
      rd = {rd[30:0], sdo};
      // status pin watched once the command is known
      if (i == 4) held = status_out;
      if (i > 4 && status_out !== held) status_moved = 1'b1;
      sclk <= 1'b0;
      repeat (3) @(posedge clk);
    end
    frame_select_n <= 1'b1;
    // a released line shows the inverse, never a stale copy
    sdi <= ~sdi;
    repeat (4) @(posedge clk);
  endtask
endmodule // acr_spi_host

// ==== verif/acr_config_register_tb.sv ====
// self-checking bench of the converter configuration register
`timescale 1ns/1ns
module acr_config_register_tb;
  logic clk, sys_rst, conversion_start_n, chain_serial_in, channel_tag, wiggle;
  logic eoc_level, int_level, osc_tick, sclk, frame_select_n, sdi, status_moved;
  logic sdo, sdo_oe, status_out, status_oe, chain_bit, auto_channel_seq, manual_trigger;
  logic auto_nap_en, nap_powerdown, deep_powerdown, tag_enable, chain_mode, soft_reset;
  logic conv_clock, conv_start;
  logic [15:0] conv_result;
  logic [11:0] config_word, cfg;
  logic [31:0] rd;
  logic [7:0] dec;
  int error_cnt = 0, samples_checked = 0, n_start = 0, n_conv_clock = 0, n_srst = 0, s0, c0;
  int n_oe = 0, o0;
  assign dec = {auto_channel_seq, manual_trigger, auto_nap_en, nap_powerdown, deep_powerdown,
    tag_enable, chain_mode, status_oe};
  acr_config_register i_dut (
    .clk, .sys_rst, .sclk, .frame_select_n, .sdi, .conversion_start_n, .chain_serial_in,
    .conv_result, .channel_tag, .eoc_level, .int_level, .osc_tick, .sdo, .sdo_oe, .status_out,
    .status_oe, .chain_bit, .config_word, .auto_channel_seq, .manual_trigger, .auto_nap_en,
    .nap_powerdown, .deep_powerdown, .tag_enable, .chain_mode, .soft_reset, .conv_clock,
    .conv_start
  );
  acr_spi_host i_host (.clk, .sclk, .frame_select_n, .sdi, .sdo, .status_out, .status_moved);
  // ********************************************************************
  // clock, pulse counters, random pin activity
  // ********************************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // one-clock pulses are counted so checks need not hit the exact cycle
  always @(posedge clk) begin
    if (conv_start === 1'b1) n_start <= n_start + 1;
    if (conv_clock === 1'b1) n_conv_clock <= n_conv_clock + 1;
    if (soft_reset === 1'b1) n_srst <= n_srst + 1;
    if (sdo_oe === 1'b1) n_oe <= n_oe + 1;
    if (wiggle) begin
      eoc_level <= 1'($urandom);
      int_level <= 1'($urandom);
      chain_serial_in <= 1'($urandom);
    end
  end
  // ********************************************************************
  // expectations and shared tasks
  // ********************************************************************
  function automatic logic [31:0] exp_rb(input logic [15:0] res, input logic [11:0] v);
    return {16'h0000, res[15:12], v};
  endfunction
  function automatic logic [31:0] exp_dec(input logic [11:0] v);
    return {24'h000000, v[11], v[9], v[9] & ~v[4], ~v[3], ~v[2], v[1], ~v[5], v[5]};
  endfunction
  function automatic logic exp_stat(input logic [11:0] v, input logic e, input logic i);
    return (v[6] ? e : i) ^ v[7];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] v);
    i_host.xfer(16, {16'h0000, acr_pkg::CMD_WRITE_CFG, v}, rd);
  endtask
  task automatic rb(input logic [11:0] v);
    @(posedge clk);
    conv_result <= 16'($urandom);
    o0 = n_oe;
    i_host.xfer(16, {16'h0000, acr_pkg::CMD_READ_CFG, 12'h000}, rd);
    chk(rd, exp_rb(conv_result, v));
    // output enabled for every clock of the 3 + 6 * 16 clock low frame
    chk(n_oe - o0, 3 + 6 * 16);
  endtask
  // oscillator ticks, spaced so each shows as its own pulse
  task automatic osc(input int n);
    repeat (n) begin
      @(posedge clk) osc_tick <= 1'b1;
      @(posedge clk) osc_tick <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // watchdog: the sequence needs a few thousand cycles
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
  // ********************************************************************
  // main sequence
  // ********************************************************************
  initial begin
    void'($urandom(73869));
    {sys_rst, conversion_start_n} = 2'h3;
    {chain_serial_in, channel_tag, eoc_level, int_level, osc_tick, wiggle} = 6'h00;
    conv_result = 16'h0000;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk(config_word, acr_pkg::CFG_ALL);
    chk(dec, exp_dec(acr_pkg::CFG_ALL));
    i_host.xfer(16, {16'h0000, acr_pkg::CMD_READ_CFG, 12'h000}, rd);
    chk(rd, 32'h0000ffff);
    // word 001 then seven random words written, decoded and read back under pin activity
    for (int k = 0; k < 8; k++) begin
      cfg = (k == 0) ? 12'h001 : 12'($urandom) | 12'h001;
      @(posedge clk);
      eoc_level <= 1'($urandom);
      int_level <= 1'($urandom);
      chain_serial_in <= 1'($urandom);
      wr(cfg);
      chk(config_word, cfg);
      chk(dec, exp_dec(cfg));
      if (cfg[5]) chk(status_out, exp_stat(cfg, eoc_level, int_level));
      chk(chain_bit, ~cfg[5] & chain_serial_in);
      wiggle <= 1'b1;
      rb(cfg);
      if (cfg[5]) chk(status_moved, 1'b0);
      wiggle <= 1'b0;
    end
    // short commands: wake sets both run bits, default loads all ones
    wr(12'hff3);
    chk(dec, exp_dec(12'hff3));
    i_host.xfer(4, 32'(acr_pkg::CMD_WAKE), rd);
    chk(config_word, 12'hfff);
    wr(12'h0a5);
    i_host.xfer(4, 32'(acr_pkg::CMD_DEFAULT), rd);
    chk(config_word, acr_pkg::CFG_ALL);
    // tag bit after the sixteenth clock, off then on
    for (int t = 0; t < 2; t++) begin
      wr(t[0] ? 12'hfff : 12'hffd);
      @(posedge clk);
      conv_result <= 16'($urandom);
      channel_tag <= 1'b1;
      i_host.xfer(17, 32'h00000000, rd);
      chk(rd, {15'h0000, conv_result, t[0]});
    end
    // manual trigger, conversion clock from the serial clock
    wr(12'hbff);
    s0 = n_start;
    @(posedge clk);
    conversion_start_n <= 1'b0;
    repeat (2) @(posedge clk);
    conversion_start_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(n_start - s0, 1);
    c0 = n_conv_clock;
    osc(3);
    chk(n_conv_clock - c0, 0);
    rb(12'hbff);
    chk(n_conv_clock - c0, 8);
    // auto trigger: four oscillator clocks after the done level drops
    wr(12'h4ed);
    chk(dec, exp_dec(12'h4ed));
    @(posedge clk);
    eoc_level <= 1'b1;
    repeat (2) @(posedge clk);
    eoc_level <= 1'b0;
    repeat (2) @(posedge clk);
    s0 = n_start;
    c0 = n_conv_clock;
    osc(3);
    chk(n_start - s0, 0);
    osc(1);
    chk(n_start - s0, 1);
    chk(n_conv_clock - c0, 4);
    // software reset through bit zero, then one all-ones frame
    s0 = n_srst;
    wr(12'h7fe);
    chk(config_word, acr_pkg::CFG_ALL);
    chk(n_srst - s0, 1);
    i_host.xfer(16, {16'h0000, acr_pkg::CMD_READ_CFG, 12'h000}, rd);
    chk(rd, 32'h0000ffff);
    rb(12'hfff);
    give_verdict();
  end
endmodule // acr_config_register_tb
